// ### cpc_top.sv
// Cascade, address counter and configuration pulse control of a configuration PROM
`timescale 1ns/100ps
module cpc_top #(
   parameter int ADDR_W         = 16,
   parameter int REV_W          = 2,
   parameter int DATA_W         = 8,
   parameter int CLK_DIV        = 2,
   parameter bit PARALLEL_CAP   = 1'b1
) (
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              reset_n_i,
   // Control pins from target and upstream PROM
   input  wire logic              oe_reset_n_i,
   input  wire logic              chip_enable_n_i,
   input  wire logic              busy_i,
   input  wire logic              target_config_clock_i,
   // Configuration pulse pin, open drain
   input  wire logic              config_pulse_n_i,
   output logic                   config_pulse_n_o,
   output logic                   config_pulse_n_oe_o,
   // Revision selection
   input  wire logic              ext_select_en_i,
   input  wire logic [REV_W-1:0]  revision_select_pins_i,
   input  wire logic [REV_W-1:0]  internal_revision_select_pins_i,
   input  wire logic              revisioning_en_i,
   // JTAG load-configuration command, one-cycle pulse
   input  wire logic              jtag_config_i,
   // Clock output option
   input  wire logic              prom_clock_output_en_i,
   output logic                   prom_clock_output_o,
   output logic                   prom_clock_output_oe_o,
   // Storage array
   output logic [ADDR_W-1:0]      mem_addr_o,
   input  wire logic [DATA_W-1:0] mem_data_i,
   // Data bus and cascade
   output logic [DATA_W-1:0]      data_o,
   output logic                   data_oe_o,
   output logic                   cascade_enable_out_o,
   output logic [REV_W-1:0]       active_revision_o
);
   localparam logic [ADDR_W-1:0] TERMINAL_COUNT = '1;
   localparam int BANK_W = ADDR_W - REV_W;
   localparam logic [7:0] DIV_LAST = 8'(CLK_DIV - 1);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [cpc_pkg::PIN_W-1:0] pin_lvl;
   logic [REV_W-1:0]          rev_pin_lvl;

   cpc_sync #(.W(cpc_pkg::PIN_W), .INIT(cpc_pkg::PIN_RESET)) u_sync_ctl (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     ({ext_select_en_i, config_pulse_n_i, target_config_clock_i,
                   busy_i, chip_enable_n_i, oe_reset_n_i}),
      .level_o   (pin_lvl)
   );

   cpc_sync #(.W(REV_W), .INIT('0)) u_sync_rev (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     (revision_select_pins_i),
      .level_o   (rev_pin_lvl)
   );

   logic oe_rst_n;
   logic ce_n;
   logic busy;
   logic tclk;
   logic cf_pin_n;

   assign oe_rst_n = pin_lvl[cpc_pkg::PIN_OE_RESET_N];
   assign ce_n     = pin_lvl[cpc_pkg::PIN_CHIP_EN_N];
   assign busy     = PARALLEL_CAP && pin_lvl[cpc_pkg::PIN_BUSY]; // RULE_14
   assign tclk     = pin_lvl[cpc_pkg::PIN_TCLK];
   // Serial-only parts never look back at the pin
   assign cf_pin_n = PARALLEL_CAP ? pin_lvl[cpc_pkg::PIN_CF_N] : 1'b1; // RULE_12

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cpc_pkg::cpc_cf_state_t cf_state_reg, cf_state_next;
   logic [7:0]        cf_cnt_reg, cf_cnt_next;
   logic              cf_oe_reg, cf_oe_next;
   logic              cf_seen_reg, cf_seen_next;
   logic [REV_W-1:0]  rev_reg, rev_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic              done_reg, done_next;
   logic              tclk_d_reg, tclk_d_next;
   logic [7:0]        div_reg, div_next;
   logic              prom_clock_output_reg, prom_clock_output_next;
   logic              prom_clock_output_oe_reg, prom_clock_output_oe_next;
   logic [DATA_W-1:0] data_reg, data_next;
   logic              data_oe_reg, data_oe_next;
   logic              ceo_reg, ceo_next;

   logic              in_reset;
   logic              cf_reset;
   logic              edge_ok;
   logic [REV_W-1:0]  rev_src;
   logic [ADDR_W-1:0] start_addr;
   logic [ADDR_W-1:0] end_addr;

   always_comb begin
      in_reset   = !oe_rst_n || ce_n; // RULE_05 RULE_17
      // Also the cycle the pin rises, so the address lands on the newly sampled bank
      cf_reset   = !cf_pin_n || cf_oe_reg || !cf_seen_reg;
      rev_src    = (PARALLEL_CAP && pin_lvl[cpc_pkg::PIN_EXT_SEL]) ? rev_pin_lvl
                                                                    : internal_revision_select_pins_i;
      // Count edge from own clock output when enabled, else target clock
      if (PARALLEL_CAP && prom_clock_output_en_i) begin
         edge_ok = (div_reg == DIV_LAST) && !prom_clock_output_reg; // RULE_15
      end else begin
         edge_ok = tclk && !tclk_d_reg;
      end

      // Configuration pulse generator
      cf_state_next = cf_state_reg;
      cf_cnt_next   = cf_cnt_reg;
      cf_oe_next    = cf_oe_reg;
      rev_next      = rev_reg;
      cf_seen_next  = cf_pin_n;
      if (cf_pin_n && !cf_seen_reg && !cf_oe_reg) begin
         rev_next = rev_src; // RULE_08
      end
      unique case (cf_state_reg)
         cpc_pkg::CPC_CF_IDLE: begin
            if (jtag_config_i) begin
               cf_state_next = cpc_pkg::CPC_CF_SAMPLE;
            end
         end
         cpc_pkg::CPC_CF_SAMPLE: begin
            rev_next      = rev_src; // RULE_09
            cf_oe_next    = 1'b1;    // RULE_07
            cf_cnt_next   = cpc_pkg::CF_LOW_CYC;
            cf_state_next = cpc_pkg::CPC_CF_LOW;
         end
         cpc_pkg::CPC_CF_LOW: begin
            cf_cnt_next = cf_cnt_reg - 8'h01; // RULE_21
            if (cf_cnt_reg == 8'h01) begin
               cf_oe_next    = 1'b0;
               cf_state_next = cpc_pkg::CPC_CF_IDLE;
            end
         end
      endcase
      // Start follows the revision being sampled now, end the one in force
      if (PARALLEL_CAP && revisioning_en_i) begin
         start_addr = {rev_next, {BANK_W{1'b0}}}; // RULE_20
         end_addr   = {rev_reg, {BANK_W{1'b1}}};
      end else begin
         start_addr = '0;
         end_addr   = TERMINAL_COUNT;
      end

      // Clock output divider
      tclk_d_next    = tclk;
      prom_clock_output_oe_next = PARALLEL_CAP && prom_clock_output_en_i && !in_reset && !done_reg;
      div_next       = '0;
      prom_clock_output_next    = 1'b0;
      if (prom_clock_output_oe_next) begin
         div_next    = (div_reg == DIV_LAST) ? 8'h00 : div_reg + 8'h01;
         prom_clock_output_next = (div_reg == DIV_LAST) ? !prom_clock_output_reg : prom_clock_output_reg;
      end

      // Address counter and outputs
      addr_next    = addr_reg;
      done_next    = done_reg;
      data_next    = data_reg;
      data_oe_next = data_oe_reg;
      ceo_next     = ceo_reg;
      if (in_reset) begin
         addr_next    = start_addr; // RULE_17
         done_next    = 1'b0;
         data_oe_next = 1'b0;
         ceo_next     = 1'b1;
      end else if (cf_reset) begin
         addr_next    = start_addr;
         done_next    = 1'b0;
         data_oe_next = 1'b1;
         data_next    = mem_data_i;
         ceo_next     = 1'b1;
      end else if (done_reg) begin
         data_oe_next = 1'b0; // RULE_03
         ceo_next     = (addr_reg != TERMINAL_COUNT);
      end else if (busy) begin
         data_oe_next = 1'b1; // RULE_19
      end else begin
         data_oe_next = 1'b1; // RULE_04
         data_next    = mem_data_i;
         if (edge_ok) begin
            if (addr_reg == end_addr) begin
               done_next = 1'b1; // RULE_18
            end else begin
               addr_next = addr_reg + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cf_state_reg  <= cpc_pkg::CPC_CF_IDLE;
         cf_cnt_reg    <= 8'h00;
         cf_oe_reg     <= 1'b0;
         cf_seen_reg   <= 1'b1;
         rev_reg       <= '0;
         addr_reg      <= '0;
         done_reg      <= 1'b0;
         tclk_d_reg    <= 1'b0;
         div_reg       <= 8'h00;
         prom_clock_output_reg    <= 1'b0;
         prom_clock_output_oe_reg <= 1'b0;
         data_reg      <= '0;
         data_oe_reg   <= 1'b0;
         ceo_reg       <= 1'b1;
      end else begin
         cf_state_reg  <= cf_state_next;
         cf_cnt_reg    <= cf_cnt_next;
         cf_oe_reg     <= cf_oe_next;
         cf_seen_reg   <= cf_seen_next;
         rev_reg       <= rev_next;
         addr_reg      <= addr_next;
         done_reg      <= done_next;
         tclk_d_reg    <= tclk_d_next;
         div_reg       <= div_next;
         prom_clock_output_reg    <= prom_clock_output_next;
         prom_clock_output_oe_reg <= prom_clock_output_oe_next;
         data_reg      <= data_next;
         data_oe_reg   <= data_oe_next;
         ceo_reg       <= ceo_next;
      end
   end

   assign config_pulse_n_o       = 1'b0;
   assign config_pulse_n_oe_o    = cf_oe_reg;
   assign prom_clock_output_o    = prom_clock_output_reg;
   assign prom_clock_output_oe_o = prom_clock_output_oe_reg;
   assign mem_addr_o             = addr_reg;
   assign data_o                 = data_reg;
   assign data_oe_o              = data_oe_reg;
   assign cascade_enable_out_o   = ceo_reg;
   assign active_revision_o      = rev_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   // Length of the current run of pulse drive, for the width check
   logic [7:0] cf_hi_cnt_reg, cf_hi_cnt_next;

   always_comb begin
      cf_hi_cnt_next = cf_oe_reg ? cf_hi_cnt_reg + 8'h01 : 8'h00;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cf_hi_cnt_reg <= 8'h00;
      end else begin
         cf_hi_cnt_reg <= cf_hi_cnt_next;
      end
   end

   cf_width_a: assert property ($fell(cf_oe_reg) |-> cf_hi_cnt_reg == cpc_pkg::CF_LOW_CYC) // RULE_07
      else $error("config pulse width wrong");
   cf_once_a: assert property ($fell(cf_oe_reg) |=> !cf_oe_reg) // RULE_07
      else $error("config pulse repeated");
   jtag_pulse_a: assert property (jtag_config_i && cf_state_reg == cpc_pkg::CPC_CF_IDLE
                                  |-> ##2 cf_oe_reg) // RULE_07
      else $error("jtag command gave no pulse");
   rev_first_a: assert property ($rose(cf_oe_reg) |-> rev_reg == $past(rev_src)) // RULE_09
      else $error("revision not sampled before pulse");
   reset_hold_a: assert property (in_reset |=> ceo_reg && !data_oe_reg
                                  && addr_reg == $past(start_addr)) // RULE_17
      else $error("reset state not held");
   busy_hold_a: assert property (!in_reset && !cf_reset && !done_reg && busy
                                 |=> $stable(addr_reg) && $stable(data_reg)) // RULE_19
      else $error("busy did not hold output");
   end_stop_a: assert property (done_reg && !in_reset && !cf_reset
                                |=> $stable(addr_reg) && !data_oe_reg) // RULE_18
      else $error("counter passed end address");
   ceo_low_a: assert property (done_reg && addr_reg == TERMINAL_COUNT
                               && !in_reset && !cf_reset |=> !ceo_reg) // RULE_03
      else $error("cascade enable not low at end");
   enable_now_a: assert property (!in_reset && !cf_reset && !done_reg |=> data_oe_reg) // RULE_04
      else $error("data not enabled");
   count_step_a: assert property (!in_reset && !cf_reset && !done_reg && !busy && edge_ok
                                  && addr_reg != end_addr |=> addr_reg == $past(addr_reg) + 1'b1) // RULE_18
      else $error("counter did not advance");

   jtag_cfg_c: cover property (jtag_config_i ##[1:30] $fell(cf_oe_reg));
   cascade_c:  cover property ($fell(ceo_reg));
   busy_c:     cover property (busy && data_oe_reg [*3]);
   rev_c:      cover property (revisioning_en_i && done_reg && addr_reg != TERMINAL_COUNT);
endmodule

// ### cpc_pkg.sv
// Constants and types for the configuration PROM cascade control block
// Behaviour
// (RULE_01) Board wires each cascade enable output to the next PROM's chip enable.
// (RULE_02) Cascaded PROMs share one clock line and one common data bus.
// (RULE_03) After the last word is read, drive cascade enable low and tristate data.
// (RULE_04) A PROM seeing chip enable low enables its data outputs at once.
// (RULE_05) Address counter resets when output-enable/reset goes low or chip enable high.
// (RULE_06) Target configuration starts at power up, by program pulse, or by JTAG.
// (RULE_07) JTAG load-configuration drives the pulse pin low once, 300 to 500 ns.
// (RULE_08) Revision is sampled on the pulse pin's rising edge, from pins or bits.
// (RULE_09) On JTAG load-configuration, sample the revision first, then pulse.
// (RULE_10) With revisioning, the pulse pin goes to the target's program input.
// (RULE_11) Unused and unconnected, the pulse pin is tied high on the board.
// (RULE_12) Pulse pin is output-only on serial parts, bidirectional on parallel parts.
// (RULE_13) Target chip select and write strobe are held low externally.
// (RULE_14) Busy exists only on parallel parts, needed for fast byte-wide loading.
// (RULE_15) Parallel part may supply the target clock from its clock output.
// (RULE_16) Mixed chains only when clock output, decompression and revisions unused.
// (RULE_17) While in reset: counter held, cascade enable high, outputs tristated.
// (RULE_18) Counter advances per valid clock edge, stops at the end, then tristates.
// (RULE_19) While busy is high, address and data outputs hold unchanged.
// (RULE_20) Revision reset starts at its start address and stops at its end.
// (RULE_21) Pulse width is counted in internal clock cycles inside the window.
package cpc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 25;
   localparam int CF_LOW_MIN_NS  = 300;
   localparam int CF_LOW_MAX_NS  = 500;
   localparam int CF_LOW_MIN_CYC = (CF_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CF_LOW_MAX_CYC = CF_LOW_MAX_NS / CLK_PERIOD_NS;
   localparam logic [7:0] CF_LOW_CYC = 8'(CF_LOW_MIN_CYC);

   // ----------------------------------------------------------------
   // Pin sync vector layout
   // ----------------------------------------------------------------
   localparam int PIN_OE_RESET_N = 0;
   localparam int PIN_CHIP_EN_N  = 1;
   localparam int PIN_BUSY       = 2;
   localparam int PIN_TCLK       = 3;
   localparam int PIN_CF_N       = 4;
   localparam int PIN_EXT_SEL    = 5;
   localparam int PIN_W          = 6;
   localparam logic [PIN_W-1:0] PIN_RESET = 6'h13;

   // ----------------------------------------------------------------
   // Pulse generator states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CPC_CF_IDLE, CPC_CF_SAMPLE, CPC_CF_LOW} cpc_cf_state_t;
endpackage

// ### cpc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module cpc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         reset_n_i,
   // Pins
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] level_reg;
   logic [W-1:0] level_next;

   // A bit changes only once the second and third stages agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         s1_reg    <= INIT;
         s2_reg    <= INIT;
         s3_reg    <= INIT;
         level_reg <= INIT;
      end else begin
         s1_reg    <= pin_i;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign level_o = level_reg;
endmodule

// ### cpc_target_model.sv
// Target configuration port model with the stored image behind the address bus
`timescale 1ns/100ps
module cpc_target_model (
   // Clock and commands from the bench
   input  wire logic       sys_clk_i,
   input  wire logic       run_i,
   input  wire logic       busy_req_i,
   input  wire logic       ext_prog_i,
   // Device side
   input  wire logic       cf_oe_i,
   input  wire logic [3:0] addr_i,
   output logic            target_config_clock_o,
   output logic            busy_o,
   output logic            cf_n_o,
   output logic [7:0]      mem_data_o
);
   logic [2:0] ph_reg = 3'h0;
   initial target_config_clock_o = 1'b0;
   // Clock stands low between frames, five cycles per phase inside them
   always @(posedge sys_clk_i) begin
      if (!run_i) begin
         ph_reg <= 3'h0;
         target_config_clock_o <= 1'b0;
      end else if (ph_reg == 3'h4) begin
         ph_reg <= 3'h0;
         target_config_clock_o <= ~target_config_clock_o;
      end else begin
         ph_reg <= ph_reg + 3'h1;
      end
   end
   assign busy_o = busy_req_i;
   // Pulled up; low while either party pulls it
   assign cf_n_o = ~(cf_oe_i | ext_prog_i);
   // Single all-parallel-capable PROM; chip select and write strobe held low at target
   assign mem_data_o = {addr_i, ~addr_i} ^ 8'h5A;
endmodule

// ### tb_top.sv
// Self-checking bench for the cascade control block
`timescale 1ns/100ps
module tb_top;
   logic sys_clk_i = 1'b0, reset_n_i = 1'b0, oe_reset_n = 1'b0, chip_en_n = 1'b1;
   logic busy_req = 1'b0, ext_prog = 1'b0, run = 1'b0, ext_sel = 1'b0, rev_en = 1'b0;
   logic jtag = 1'b0, ck_en = 1'b0;
   logic [1:0] rev_pins = 2'h0, int_rev = 2'h0;
   wire logic tclk, busy, cf_n, cf_oe, ck_oe, data_oe, cascade_enable_out;
   wire logic [3:0] addr;
   wire logic [7:0] mem, dout;
   wire logic [1:0] act_rev;
   int fail_count = 0, n_compared = 0, cycles = 0;

   initial forever #12.5 sys_clk_i = ~sys_clk_i;

   cpc_top #(.ADDR_W(4), .REV_W(2), .DATA_W(8), .CLK_DIV(2), .PARALLEL_CAP(1'b1)) i_dut (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .oe_reset_n_i(oe_reset_n),
      .chip_enable_n_i(chip_en_n), .busy_i(busy), .target_config_clock_i(tclk),
      .config_pulse_n_i(cf_n), .config_pulse_n_o(), .config_pulse_n_oe_o(cf_oe),
      .ext_select_en_i(ext_sel), .revision_select_pins_i(rev_pins),
      .internal_revision_select_pins_i(int_rev), .revisioning_en_i(rev_en), .jtag_config_i(jtag),
      .prom_clock_output_en_i(ck_en), .prom_clock_output_o(), .prom_clock_output_oe_o(ck_oe),
      .mem_addr_o(addr), .mem_data_i(mem), .data_o(dout), .data_oe_o(data_oe),
      .cascade_enable_out_o(cascade_enable_out), .active_revision_o(act_rev));

   cpc_target_model i_tgt (
      .sys_clk_i(sys_clk_i), .run_i(run), .busy_req_i(busy_req), .ext_prog_i(ext_prog),
      .cf_oe_i(cf_oe), .addr_i(addr), .target_config_clock_o(tclk), .busy_o(busy),
      .cf_n_o(cf_n), .mem_data_o(mem));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   // One target clock edge, then let it pass the synchroniser
   task automatic step(input int n);
      repeat (n) begin
         @(posedge tclk);
         cyc(7);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic t_reset;
      cyc(8);
      chk("ceo in reset", 16'h1, cascade_enable_out);
      chk("data_oe in reset", 16'h0, data_oe);
      chk("addr in reset", 16'h0, addr);
      oe_reset_n <= 1'b1;
      cyc(8);
      chk("data_oe ce high", 16'h0, data_oe);
      $display("test reset done");
   endtask
   task automatic t_stream;
      chip_en_n <= 1'b0;
      cyc(6);
      chk("data_oe on enable", 16'h1, data_oe);
      run <= 1'b1;
      for (int i = 1; i < 16; i++) begin
         step(1);
         chk("addr count", 16'(i), addr);
         chk("data word", 16'({i[3:0], ~i[3:0]} ^ 8'h5A), dout);
      end
      step(1);
      run <= 1'b0;
      chk("addr at end", 16'hF, addr);
      chk("data_oe at end", 16'h0, data_oe);
      chk("ceo at end", 16'h0, cascade_enable_out);
      chip_en_n <= 1'b1;
      cyc(6);
      chk("addr after ce", 16'h0, addr);
      chk("ceo after ce", 16'h1, cascade_enable_out);
      $display("test stream done");
   endtask
   task automatic t_busy;
      chip_en_n <= 1'b0;
      run <= 1'b1;
      step(2);
      busy_req <= 1'b1;
      step(3);
      chk("addr busy", 16'h2, addr);
      chk("data busy", 16'h77, dout);
      chk("data_oe busy", 16'h1, data_oe);
      busy_req <= 1'b0;
      step(1);
      chk("addr after busy", 16'h3, addr);
      oe_reset_n <= 1'b0;
      cyc(6);
      run <= 1'b0;
      chk("addr oe low", 16'h0, addr);
      chk("data_oe oe low", 16'h0, data_oe);
      oe_reset_n <= 1'b1;
      chip_en_n <= 1'b1;
      $display("test busy done");
   endtask
   task automatic t_jtag;
      int k;
      int_rev <= 2'h2;
      @(posedge sys_clk_i) jtag <= 1'b1;
      @(posedge sys_clk_i) jtag <= 1'b0;
      k = 0;
      while (cf_oe !== 1'b1 && k < 6) begin
         k++;
         @(posedge sys_clk_i);
      end
      chk("rev before pulse", 16'h2, act_rev);
      k = 0;
      while (cf_oe === 1'b1 && k < 100) begin
         k++;
         @(posedge sys_clk_i);
      end
      chk("pulse cycles", 16'(cpc_pkg::CF_LOW_CYC), 16'(k));
      k = 0;
      repeat (40) begin
         @(posedge sys_clk_i);
         if (cf_oe !== 1'b0) k++;
      end
      chk("single pulse", 16'h0, 16'(k));
      $display("test jtag done");
   endtask
   task automatic t_rev;
      rev_en <= 1'b1;
      cyc(2);
      chip_en_n <= 1'b0;
      cyc(8);
      chk("bank start", 16'h8, addr);
      run <= 1'b1;
      step(4);
      run <= 1'b0;
      chk("bank end", 16'hB, addr);
      chk("data_oe bank end", 16'h0, data_oe);
      chk("ceo bank end", 16'h1, cascade_enable_out);
      ext_sel <= 1'b1;
      rev_pins <= 2'h3;
      ext_prog <= 1'b1;
      cyc(20);
      chk("addr cf low", 16'h8, addr);
      chk("data_oe cf low", 16'h1, data_oe);
      ext_prog <= 1'b0;
      cyc(10);
      chk("rev from pins", 16'h3, act_rev);
      chk("new bank start", 16'hC, addr);
      run <= 1'b1;
      step(4);
      run <= 1'b0;
      chk("ceo last bank", 16'h0, cascade_enable_out);
      chk("addr last bank", 16'hF, addr);
      chip_en_n <= 1'b1;
      $display("test revision done");
   endtask
   task automatic t_prom_clock_output;
      rev_en <= 1'b0;
      cyc(8);
      chip_en_n <= 1'b0;
      ck_en <= 1'b1;
      cyc(30);
      chk("prom_clock_output enabled", 16'h1, ck_oe);
      chk("counted on prom_clock_output", 16'h1, 16'(addr > 4'h2));
      chip_en_n <= 1'b1;
      cyc(8);
      chk("prom_clock_output off in reset", 16'h0, ck_oe);
      ck_en <= 1'b0;
      $display("test prom_clock_output done");
   endtask

   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      cyc(16);
      reset_n_i <= 1'b1;
      t_reset();
      t_stream();
      t_busy();
      t_jtag();
      t_rev();
      t_prom_clock_output();
      give_verdict();
   end
endmodule
